// file: host_sampler.sv
// host model: counts strobes and samples the codes
`timescale 1ns/10ps
module host_sampler (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] column_code_i,
  input  wire logic [2:0] row_code_i,
  input  wire logic       touch_hit_i,
  input  wire logic       cycle_done_i,
  output int              done_count_o = 0,
  output int              cycle_hits_o = 0,
  output logic [6:0]      done_code_o = 7'h0
);
  int   hits = 0;
  logic hit_q = 1'b0;
  logic done_q = 1'b0;
  always @(posedge sys_clk_i) begin
    hit_q  <= touch_hit_i;
    done_q <= cycle_done_i;
    if (touch_hit_i && !hit_q) hits <= hits + 1;
    if (cycle_done_i && !done_q) begin
      done_code_o  <= {column_code_i, row_code_i};
      cycle_hits_o <= hits;
      hits         <= 0;
      done_count_o <= done_count_o + 1;
    end
  end
endmodule : host_sampler

// file: pulse_timer.sv
// one-shot down counter measuring a strobe length
`timescale 1ns/10ps
module pulse_timer #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] length_i,
  output logic                  busy_o
);
  logic [WIDTH-1:0] count;
  wire              running = (count != '0);

  initial begin
    if (WIDTH < 2) begin
      $error("pulse timer needs at least 2 bits");
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= length_i;
    end else if (running) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= start_i | (count > WIDTH'(1));
    end
  end
endmodule : pulse_timer

// file: touch_matrix_auto_scanner.sv
// scan sequencer, position latch and strobes for the touch matrix
`timescale 1ns/10ps
`include "touch_scan_defs.svh"
module touch_matrix_auto_scanner
  import touch_scan_pkg::*;
#(
  parameter int unsigned NUM_COLS       = `NUM_COLS,
  parameter int unsigned NUM_ROWS       = `NUM_ROWS,
  parameter int unsigned HIT_PULSE_CYC  = `HIT_PULSE_CYC,
  parameter int unsigned DONE_PULSE_CYC = `DONE_PULSE_CYC,
  parameter int unsigned CYCLE_MAX_CYC  = `CYCLE_MAX_CYC
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [NUM_COLS*NUM_ROWS-1:0] sense_i,
  input  wire logic                  standby_scan_n_i,
  input  wire logic                  continuous_scan_n_i,
  output logic [3:0]                 column_code_o,
  output logic [2:0]                 row_code_o,
  output logic                       touch_hit_o,
  output logic                       cycle_done_o
);
  localparam int unsigned KEYS = NUM_COLS * NUM_ROWS;
  localparam int unsigned TW   = 20;
  localparam logic [TW-1:0] HIT_LEN  = TW'(HIT_PULSE_CYC);
  localparam logic [TW-1:0] DONE_LEN = TW'(DONE_PULSE_CYC);

  // refuse any matrix but 16 by 8, pulse lengths the timer width cannot hold, and a cycle over its limit
  initial begin
    if (NUM_COLS != 16) begin
      $error("matrix must have 16 columns");
    end
    if (NUM_ROWS != 8) begin
      $error("matrix must have 8 rows");
    end
    if (HIT_PULSE_CYC < 1 || HIT_PULSE_CYC >= (1 << TW)) begin
      $error("hit pulse length out of range");
    end
    if (DONE_PULSE_CYC < 1 || DONE_PULSE_CYC >= (1 << TW)) begin
      $error("done pulse length out of range");
    end
    // only the untouched cycle is bounded; every touched key adds one hit pulse
    if (KEYS + DONE_PULSE_CYC + 2 > CYCLE_MAX_CYC) begin
      $error("scan cycle cannot fit the longest cycle time");
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [KEYS-1:0] sense_meta;
  logic [KEYS-1:0] sense;
  logic [1:0]      ctl_meta;
  logic [1:0]      ctl;

  // mode pins reset to their idle high level, so reset causes no false start

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_meta <= '0;
      sense      <= '0;
      ctl_meta   <= 2'h3;
      ctl        <= 2'h3;
    end else begin
      sense_meta <= sense_i;
      sense      <= sense_meta;
      ctl_meta   <= {continuous_scan_n_i, standby_scan_n_i};
      ctl        <= ctl_meta;
    end
  end

  wire standby_mode    = ~ctl[0];
  wire continuous_mode = ~ctl[1];
  wire any_touch       = |sense;

  //////////////////////////////////////////////////////////////////////
  // scan order: column 1 first, row 8 first within a column, so a later
  // hit overwrites the latch and the final value wins by priority
  scan_state_t     state;
  scan_state_t     next_state;
  logic [3:0]      col;
  logic [2:0]      row;
  logic            cycle_active;

  wire [6:0] key_index  = {col, 3'h7 - row};
  wire       key_hit    = sense[key_index];
  wire       last_key   = (col == 4'hf) && (row == 3'h0);
  wire       may_start  = continuous_mode | (standby_mode & any_touch);
  wire       keep_going = continuous_mode | cycle_active | any_touch;
  // a finished cycle repeats only while a mode still asks for it
  wire       rescan     = keep_going && may_start;
  logic      hit_busy;
  logic      done_busy;
  wire       hit_start  = (state == ST_STEP) && key_hit;
  wire       done_start = (state == ST_STEP) && !key_hit && last_key;
  wire       hit_end    = (state == ST_HIT) && !hit_busy && !hit_start;
  wire       advance    = ((state == ST_STEP) && !key_hit) || hit_end;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (may_start) begin
          next_state = ST_STEP;
        end
      end
      ST_STEP: begin
        if (key_hit) begin
          next_state = ST_HIT;
        end else if (last_key) begin
          next_state = ST_DONE;
        end
      end
      ST_HIT: begin
        if (hit_end) begin
          next_state = last_key ? ST_DONE : ST_STEP;
        end
      end
      ST_DONE: begin
        if (!done_busy && !done_start) begin
          next_state = rescan ? ST_STEP : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire leave_done = (state == ST_DONE) && (next_state != ST_DONE);
  wire wrap       = advance && last_key;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // a started cycle always completes, even if the touch goes away
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_active <= 1'b0;
    end else if (state == ST_IDLE && may_start) begin
      cycle_active <= 1'b1;
    end else if (leave_done) begin
      cycle_active <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col <= 4'h0;
      row <= 3'h7;
    end else if (state == ST_IDLE || wrap) begin
      col <= 4'h0;
      row <= 3'h7;
    end else if (advance) begin
      row <= row - 3'h1;
      if (row == 3'h0) begin
        col <= col + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // position latch: loads only on a hit, so idle and misses hold it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      column_code_o <= 4'h0;
      row_code_o    <= 3'h0;
    end else if (hit_start) begin
      column_code_o <= col;
      row_code_o    <= row;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // strobes
  // done timer starts from a plain last-key step or from the end of a last-key hit
  wire done_fire = done_start | (hit_end && last_key);

  pulse_timer #(
    .WIDTH (TW)
  ) u_hit_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (hit_start),
    .length_i  (HIT_LEN),
    .busy_o    (hit_busy)
  );

  pulse_timer #(
    .WIDTH (TW)
  ) u_done_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (done_fire),
    .length_i  (DONE_LEN),
    .busy_o    (done_busy)
  );

  // codes are already stable when either strobe rises
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      touch_hit_o <= 1'b0;
    end else begin
      touch_hit_o <= hit_busy;
    end
  end

  // the extra stage costs a clock but keeps both strobes clean flop outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_done_o <= 1'b0;
    end else begin
      cycle_done_o <= done_busy;
    end
  end
endmodule : touch_matrix_auto_scanner

// file: touch_matrix_auto_scanner_test.sv
// self-checking bench for the touch scanner
`timescale 1ns/10ps
module touch_matrix_auto_scanner_test;
  logic         sys_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic [127:0] sense_i = 128'h0;
  logic         standby_scan_n_i = 1'b1;
  logic         continuous_scan_n_i = 1'b1;
  logic [3:0]   column_code_o;
  logic [2:0]   row_code_o;
  logic         touch_hit_o;
  logic         cycle_done_o;
  logic [6:0]   done_code;
  int           done_count;
  int           cycle_hits;
  int           miscompares = 0;
  int           total_checks = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  touch_matrix_auto_scanner #(.HIT_PULSE_CYC(4), .DONE_PULSE_CYC(8), .CYCLE_MAX_CYC(2000)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sense_i(sense_i),
    .standby_scan_n_i(standby_scan_n_i), .continuous_scan_n_i(continuous_scan_n_i),
    .column_code_o(column_code_o), .row_code_o(row_code_o),
    .touch_hit_o(touch_hit_o), .cycle_done_o(cycle_done_o));
  host_sampler u_host (
    .sys_clk_i(sys_clk_i), .column_code_i(column_code_o), .row_code_i(row_code_o),
    .touch_hit_i(touch_hit_o), .cycle_done_i(cycle_done_o), .done_count_o(done_count),
    .cycle_hits_o(cycle_hits), .done_code_o(done_code));
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task wait_done(input int n);
    int start;
    start = done_count;
    for (int i = 0; i < 3000 && done_count < start + n; i++) @(posedge sys_clk_i);
    if (done_count < start + n) begin
      miscompares++;
      results();
    end
  endtask : wait_done
  // bit index is col*8 + (7-row); the checks read the second of two whole cycles
  task press(input int c1, r1, c2, r2, ec, er, nh);
    int n;
    sense_i <= (128'h1 << (c1 * 8 + 7 - r1)) | (128'h1 << (c2 * 8 + 7 - r2));
    wait_done(2);
    check(done_code, {ec[3:0], er[2:0]});
    check(cycle_hits, nh);
    n = done_count;
    sense_i <= 128'h0;
    repeat (300) @(posedge sys_clk_i);
    check({column_code_o, row_code_o}, {ec[3:0], er[2:0]});
    check(done_count, n);
  endtask : press
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    sense_i <= 128'h1 << 100;
    repeat (300) @(posedge sys_clk_i);
    check(done_count, 0);
    check({column_code_o, row_code_o}, 7'h0);
    sense_i <= 128'h0;
    standby_scan_n_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    press(11, 3, 11, 3, 11, 3, 1);
    press(7, 4, 11, 2, 11, 2, 2);
    press(7, 4, 3, 1, 7, 4, 2);
    press(5, 6, 5, 1, 5, 1, 2);
    press(0, 0, 15, 7, 15, 7, 2);
    standby_scan_n_i <= 1'b1;
    continuous_scan_n_i <= 1'b0;
    wait_done(1);
    continuous_scan_n_i <= 1'b1;
    check(cycle_hits, 0);
    continuous_scan_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    continuous_scan_n_i <= 1'b1;
    wait_done(1);
    check(cycle_hits, 0);
    repeat (300) @(posedge sys_clk_i);
    check({column_code_o, row_code_o}, 7'h7f);
    results();
  end
endmodule : touch_matrix_auto_scanner_test

// file: touch_scan_defs.svh
// constants for the touch matrix auto scanner
`ifndef TOUCH_SCAN_DEFS_SVH
`define TOUCH_SCAN_DEFS_SVH
`define CLK_FREQ_HZ        125000000
`define HIT_PULSE_US       2000
`define DONE_PULSE_US      4000
`define CYCLE_MAX_US       64000
`define CYC_PER_US         125
`define HIT_PULSE_CYC      (`HIT_PULSE_US * `CYC_PER_US)
`define DONE_PULSE_CYC     (`DONE_PULSE_US * `CYC_PER_US)
`define CYCLE_MAX_CYC      (`CYCLE_MAX_US * `CYC_PER_US)
`define NUM_COLS           16
`define NUM_ROWS           8
`endif

// file: touch_scan_pkg.sv
// types for the touch matrix auto scanner
package touch_scan_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_HIT  = 2'b10,
    ST_DONE = 2'b11
  } scan_state_t;
endpackage : touch_scan_pkg

// file: touch_scan_properties.sv
// assertions on the touch scanner ports
`timescale 1ns/10ps
module touch_scan_properties #(
  parameter int unsigned HIT_PULSE_CYC  = 4,
  parameter int unsigned DONE_PULSE_CYC = 8
) (
  input wire logic         sys_clk_i,
  input wire logic         rst_n_i,
  input wire logic [127:0] sense_i,
  input wire logic         standby_scan_n_i,
  input wire logic         continuous_scan_n_i,
  input wire logic [3:0]   column_code_o,
  input wire logic [2:0]   row_code_o,
  input wire logic         touch_hit_o,
  input wire logic         cycle_done_o
);
  logic [31:0] hit_len;
  logic [31:0] done_len;
  // pulse lengths exceed the repetition limit, so count them
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_len  <= 32'h0;
      done_len <= 32'h0;
    end else begin
      hit_len  <= touch_hit_o ? hit_len + 32'h1 : 32'h0;
      done_len <= cycle_done_o ? done_len + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_hit_len; $fell(touch_hit_o) |-> hit_len == HIT_PULSE_CYC; endproperty
  a_hit_len: assert property (p_hit_len) else $error("hit pulse length");
  property p_done_len; $fell(cycle_done_o) |-> done_len == DONE_PULSE_CYC; endproperty
  a_done_len: assert property (p_done_len) else $error("done pulse length");
  property p_code_cause;
    $changed({column_code_o, row_code_o}) |-> ##[1:3] $rose(touch_hit_o);
  endproperty
  a_code_cause: assert property (p_code_cause) else $error("codes moved without hit");
  property p_code_hold; touch_hit_o |-> $stable({column_code_o, row_code_o}); endproperty
  a_code_hold: assert property (p_code_hold) else $error("codes moved in hit");
  property p_excl; !(touch_hit_o && cycle_done_o); endproperty
  a_excl: assert property (p_excl) else $error("hit during done");
  property p_wake; $rose(|sense_i) && !standby_scan_n_i |-> ##[1:1000] touch_hit_o; endproperty
  a_wake: assert property (p_wake) else $error("standby did not wake");
  property p_cont; $fell(continuous_scan_n_i) |-> ##[1:1000] cycle_done_o; endproperty
  a_cont: assert property (p_cont) else $error("no cycle end");
  property p_idle;
    (standby_scan_n_i && continuous_scan_n_i)[*4] ##0 $fell(cycle_done_o) |->
      (!touch_hit_o && $stable({column_code_o, row_code_o}))[*8];
  endproperty
  a_idle: assert property (p_idle) else $error("activity in idle");
endmodule : touch_scan_properties

bind touch_matrix_auto_scanner touch_scan_properties #(
  .HIT_PULSE_CYC (HIT_PULSE_CYC),
  .DONE_PULSE_CYC(DONE_PULSE_CYC)
) u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sense_i(sense_i),
  .standby_scan_n_i(standby_scan_n_i), .continuous_scan_n_i(continuous_scan_n_i),
  .column_code_o(column_code_o), .row_code_o(row_code_o),
  .touch_hit_o(touch_hit_o), .cycle_done_o(cycle_done_o)
);
